// ### src/interval_timer_control.sv
// interval timer: three counters behind a byte-wide port interface
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// one counter channel
module counter_unit
   import interval_timer_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   // host side
   input wire logic ctrl_wr_i,
   input wire logic [7:0] ctrl_i,
   input wire logic data_wr_i,
   input wire logic data_rd_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rd_byte_o,
   // counting side
   input wire logic tick_i,
   input wire logic gate_i,
   input wire logic gate_rise_i,
   output logic out_o
);
   logic [2:0] mode_ff, nxt_mode;
   logic [1:0] seq_ff, nxt_seq;
   logic bcd_ff, nxt_bcd;
   logic [15:0] cr_ff, nxt_cr, count_ff, nxt_count, latch_ff, nxt_latch;
   logic latched_ff, nxt_latched, wr_hi_ff, nxt_wr_hi;
   logic rd_hi_ff, nxt_rd_hi, load_ff, nxt_load, out_ff, nxt_out;
   cnt_state_t state_ff, nxt_state;
   logic [15:0] rd_src;
   logic [2:0] wmode;
   logic trig_mode;

   function automatic logic [15:0] dec1(input logic [15:0] v,
                                        input logic bcd);
      logic [15:0] r;
      logic borrow;
      r = v - 16'h0001;
      if (bcd) begin
         r = v;
         borrow = 1'b1;
         for (int i = 0; i < 4; i++) begin
            if (borrow) begin
               // 0000 wraps to 9999, never into hex digits
               if (r[i*4 +: 4] == 4'h0) begin
                  r[i*4 +: 4] = 4'h9;
               end else begin
                  r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction

   // m1 set means mode 2 or 3 whatever m2 holds
   assign wmode = ctrl_i[MODE_POS+1] ? {1'b0, ctrl_i[MODE_POS +: 2]}
                                     : ctrl_i[MODE_POS +: 3];
   assign trig_mode = (mode_ff == MODE_ONESHOT) ||
                      (mode_ff == MODE_HW_STROBE);
   assign rd_src = latched_ff ? latch_ff : count_ff;
   assign rd_byte_o = ((seq_ff == SEQ_MSB) ||
                       ((seq_ff == SEQ_BOTH) && rd_hi_ff)) ?
                      rd_src[15:8] : rd_src[7:0];
   assign out_o = out_ff;

   always_comb begin
      nxt_mode = mode_ff;
      nxt_seq = seq_ff;
      nxt_bcd = bcd_ff;
      nxt_cr = cr_ff;
      nxt_count = count_ff;
      nxt_latch = latch_ff;
      nxt_latched = latched_ff;
      nxt_wr_hi = wr_hi_ff;
      nxt_rd_hi = rd_hi_ff;
      nxt_load = load_ff;
      nxt_out = out_ff;
      nxt_state = state_ff;
      // counting on each rising edge of the counter clock
      if (tick_i) begin
         case (state_ff)
            ST_IDLE: begin
               if (load_ff && !trig_mode) begin
                  nxt_count = cr_ff;
                  nxt_load = 1'b0;
                  nxt_state = ST_RUN;
               end
            end
            ST_RUN: begin
               if (mode_ff == MODE_RATE || mode_ff == MODE_SQUARE) begin
                  if (!gate_i) begin
                     nxt_out = 1'b1;
                  end else if (mode_ff == MODE_RATE) begin
                     nxt_out = (count_ff != 16'h0002);
                     nxt_count = (count_ff == 16'h0001) ? cr_ff :
                                 dec1(count_ff, bcd_ff);
                  end else if (count_ff <= 16'h0002) begin
                     // odd reloads keep the extra half-period tick in both halves
                     nxt_count = cr_ff;
                     nxt_out = ~out_ff;
                  end else begin
                     nxt_count = dec1(dec1(count_ff, bcd_ff), bcd_ff);
                  end
               end else if (gate_i || trig_mode) begin
                  nxt_count = dec1(count_ff, bcd_ff);
                  if (mode_ff == MODE_TC || mode_ff == MODE_ONESHOT) begin
                     if (count_ff == 16'h0001) begin
                        nxt_out = 1'b1;
                     end
                  end else begin
                     nxt_out = (count_ff != 16'h0001);
                  end
               end
            end
            default: ;
         endcase
      end
      if (gate_rise_i && trig_mode && state_ff != ST_IDLE) begin
         nxt_count = cr_ff;
         nxt_state = ST_RUN;
         nxt_out = (mode_ff != MODE_ONESHOT);
      end
      // host writes win over counting
      if (ctrl_wr_i) begin
         if (ctrl_i[SEQ_POS +: 2] == SEQ_LATCH) begin
            if (!latched_ff) begin
               nxt_latch = count_ff;
               nxt_latched = 1'b1;
               nxt_rd_hi = 1'b0;
            end
         end else begin
            nxt_seq = ctrl_i[SEQ_POS +: 2];
            nxt_mode = wmode;
            nxt_bcd = ctrl_i[BCD_POS];
            nxt_wr_hi = 1'b0;
            nxt_rd_hi = 1'b0;
            nxt_latched = 1'b0;
            nxt_load = 1'b0;
            nxt_state = ST_IDLE;
            nxt_out = (wmode != MODE_TC);
         end
      end else if (data_wr_i) begin
         case (seq_ff)
            SEQ_LSB: nxt_cr = {8'h00, wdata_i};
            SEQ_MSB: nxt_cr = {wdata_i, 8'h00};
            default: begin
               if (wr_hi_ff) begin
                  nxt_cr[15:8] = wdata_i;
               end else begin
                  nxt_cr[7:0] = wdata_i;
               end
               nxt_wr_hi = ~wr_hi_ff;
            end
         endcase
         if (seq_ff != SEQ_BOTH || wr_hi_ff) begin
            nxt_load = 1'b1;
            if (trig_mode) begin
               nxt_state = (state_ff == ST_RUN) ? ST_RUN : ST_ARMED;
            end else if (mode_ff == MODE_TC || mode_ff == MODE_SW_STROBE ||
                         state_ff != ST_RUN) begin
               // rate modes keep running and pick up the value at reload
               nxt_state = ST_IDLE;
               nxt_out = (mode_ff != MODE_TC);
            end
         end
      end else if (data_rd_i) begin
         if (seq_ff == SEQ_BOTH) begin
            nxt_rd_hi = ~rd_hi_ff;
         end
         if (seq_ff != SEQ_BOTH || rd_hi_ff) begin
            nxt_latched = 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_ff <= MODE_TC;
         seq_ff <= SEQ_RST;
         bcd_ff <= 1'b0;
         cr_ff <= COUNT_RST;
         count_ff <= COUNT_RST;
         latch_ff <= COUNT_RST;
         latched_ff <= 1'b0;
         wr_hi_ff <= 1'b0;
         rd_hi_ff <= 1'b0;
         load_ff <= 1'b0;
         out_ff <= OUT_RST;
         state_ff <= ST_IDLE;
      end else begin
         mode_ff <= nxt_mode;
         seq_ff <= nxt_seq;
         bcd_ff <= nxt_bcd;
         cr_ff <= nxt_cr;
         count_ff <= nxt_count;
         latch_ff <= nxt_latch;
         latched_ff <= nxt_latched;
         wr_hi_ff <= nxt_wr_hi;
         rd_hi_ff <= nxt_rd_hi;
         load_ff <= nxt_load;
         out_ff <= nxt_out;
         state_ff <= nxt_state;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   logic quiet;
   assign quiet = !ctrl_wr_i && !data_wr_i && !data_rd_i;
   a_cfg_only_ctrl: assert property (!ctrl_wr_i |=>
      $stable(mode_ff) && $stable(seq_ff) && $stable(bcd_ff))
      else $error("config changed without control write");
   a_mode_decode: assert property (ctrl_wr_i &&
      ctrl_i[5:4] != SEQ_LATCH |=> mode_ff == $past(wmode) &&
      bcd_ff == $past(ctrl_i[0]))
      else $error("mode field decoded wrongly");
   a_latch_snap: assert property (ctrl_wr_i &&
      ctrl_i[5:4] == SEQ_LATCH && !latched_ff |=>
      latched_ff && latch_ff == $past(count_ff))
      else $error("latch did not snapshot count");
   a_latch_holds: assert property (latched_ff && quiet |=>
      latched_ff && $stable(latch_ff))
      else $error("latched value lost");
   a_lsb_load: assert property (data_wr_i && !ctrl_wr_i &&
      seq_ff == SEQ_LSB |=> cr_ff == {8'h00, $past(wdata_i)} && load_ff)
      else $error("low byte load wrong");
   a_two_byte_seq: assert property (data_wr_i && !ctrl_wr_i &&
      seq_ff == SEQ_BOTH && !wr_hi_ff |=>
      wr_hi_ff && cr_ff[7:0] == $past(wdata_i))
      else $error("two byte sequence broken");
   a_mode0_low: assert property (ctrl_wr_i && ctrl_i[5:4] != 2'h0 &&
      ctrl_i[3:1] == 3'h0 |=> !out_ff)
      else $error("mode 0 output not low after control");
   a_mode0_tc: assert property (quiet && tick_i && gate_i &&
      state_ff == ST_RUN && mode_ff == MODE_TC && count_ff == 16'h0001
      |=> out_ff && count_ff == 16'h0000)
      else $error("mode 0 terminal count missed");
   a_bin_dec: assert property (quiet && tick_i && gate_i && !bcd_ff &&
      state_ff == ST_RUN && mode_ff == MODE_TC |=>
      count_ff == $past(count_ff) - 16'h0001)
      else $error("binary decrement wrong");
   a_bcd_wrap: assert property (quiet && tick_i && gate_i && bcd_ff &&
      state_ff == ST_RUN && mode_ff == MODE_TC && count_ff == 16'h0
      |=> count_ff == 16'h9999)
      else $error("bcd wrap wrong");
   c_square: cover property (mode_ff == MODE_SQUARE && $rose(out_ff));
   c_oneshot: cover property (mode_ff == MODE_ONESHOT && $fell(out_ff));
   c_latch_read: cover property (latched_ff ##1 !latched_ff);
endmodule

// ==========================================================
// Summary of operation
// - three separate programmable 16-bit down counters.
// - each counter clock may run from DC to 5 MHz.
// - control word configures each counter on its own into six modes.
// - data ports at 0x20, 0x22, 0x24, control at 0x26, byte wide.
// - bits 7:6 pick counter 0, 1 or 2; code 11 is illegal.
// - bits 5:4 pick latch, low only, high only, or low then high.
// - bits 3:1 pick the mode; top bit ignored for modes 2 and 3.
// - bit 0 picks binary or four-digit BCD counting.
// - binary covers 0 to 65535, BCD covers 0 to 9999.
// - modes: terminal count, one-shot, rate, square wave, two strobes.
module interval_timer_control
   import interval_timer_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic arst_n_i,
   // host byte port
   input wire logic [7:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   // counter pins
   input wire logic [2:0] ctr_clk_i,
   input wire logic [2:0] gate_i,
   output logic [2:0] timer_out_o
);
   logic [1:0] rst_sync_ff;
   logic rst_n;
   logic [2:0] clk_s1_ff, clk_s2_ff, clk_s3_ff;
   logic [2:0] gate_s1_ff, gate_s2_ff, gate_s3_ff;
   logic [7:0] rdata_ff, nxt_rdata;
   logic [2:0] ctrl_wr, data_wr, data_rd;
   logic [7:0] rd_byte [0:2];
   logic ctrl_hit;

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // ==========================================================
   // pin synchronisers; 125 MHz sampling resolves a 5 MHz clock
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         clk_s1_ff <= 3'h0;
         clk_s2_ff <= 3'h0;
         clk_s3_ff <= 3'h0;
         gate_s1_ff <= 3'h0;
         gate_s2_ff <= 3'h0;
         gate_s3_ff <= 3'h0;
      end else begin
         clk_s1_ff <= ctr_clk_i;
         clk_s2_ff <= clk_s1_ff;
         clk_s3_ff <= clk_s2_ff;
         gate_s1_ff <= gate_i;
         gate_s2_ff <= gate_s1_ff;
         gate_s3_ff <= gate_s2_ff;
      end
   end

   // ==========================================================
   // address decode
   assign ctrl_hit = wr_i && (addr_i == CTRL_WORD_OFS);
   always_comb begin
      nxt_rdata = rdata_ff;
      if (rd_i) begin
         nxt_rdata = RDATA_RST;
      end
      for (int k = 0; k < 3; k++) begin
         // code 11 matches no counter
         ctrl_wr[k] = ctrl_hit &&
                      (wdata_i[SEL_POS +: 2] == 2'(k));
         data_wr[k] = wr_i && (addr_i == CTR_DATA_OFS[k]);
         data_rd[k] = rd_i && (addr_i == CTR_DATA_OFS[k]);
         if (data_rd[k]) begin
            nxt_rdata = rd_byte[k];
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= RDATA_RST;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end
   assign rdata_o = rdata_ff;

   for (genvar k = 0; k < 3; k++) begin : g_ctr
      counter_unit u_ctr (
         .clock_i(clock_i),
         .rst_n_i(rst_n),
         .ctrl_wr_i(ctrl_wr[k]),
         .ctrl_i(wdata_i),
         .data_wr_i(data_wr[k]),
         .data_rd_i(data_rd[k]),
         .wdata_i(wdata_i),
         .rd_byte_o(rd_byte[k]),
         .tick_i(clk_s2_ff[k] && !clk_s3_ff[k]),
         .gate_i(gate_s2_ff[k]),
         .gate_rise_i(gate_s2_ff[k] && !gate_s3_ff[k]),
         .out_o(timer_out_o[k])
      );
   end

   a_illegal_sel: assert property (@(posedge clock_i) disable iff (!rst_n)
      ctrl_hit && wdata_i[7:6] == SEL_ILLEGAL |-> ctrl_wr == 3'h0)
      else $error("illegal select reached a counter");
   a_ctrl_route: assert property (@(posedge clock_i) disable iff (!rst_n)
      ctrl_hit && wdata_i[7:6] != SEL_ILLEGAL |->
      ctrl_wr == (3'h1 << wdata_i[7:6]))
      else $error("control word routed wrongly");
   c_illegal: cover property (@(posedge clock_i) disable iff (!rst_n)
      ctrl_hit && wdata_i[7:6] == SEL_ILLEGAL);
endmodule

`default_nettype wire

// ### src/interval_timer_pkg.sv
// constants and types shared by the interval timer
package interval_timer_pkg;
   // ==========================================================
   // port addresses
   localparam logic [7:0] CTRL_WORD_OFS = 8'h26;
   localparam logic [7:0] CTR_DATA_OFS [0:2] = '{8'h20, 8'h22, 8'h24};
   // ==========================================================
   // control word fields
   localparam int SEL_POS = 6;
   localparam int SEQ_POS = 4;
   localparam int MODE_POS = 1;
   localparam int BCD_POS = 0;
   localparam logic [1:0] SEL_ILLEGAL = 2'h3;
   localparam logic [1:0] SEQ_LATCH = 2'h0;
   localparam logic [1:0] SEQ_LSB = 2'h1;
   localparam logic [1:0] SEQ_MSB = 2'h2;
   localparam logic [1:0] SEQ_BOTH = 2'h3;
   localparam logic [2:0] MODE_TC = 3'h0;
   localparam logic [2:0] MODE_ONESHOT = 3'h1;
   localparam logic [2:0] MODE_RATE = 3'h2;
   localparam logic [2:0] MODE_SQUARE = 3'h3;
   localparam logic [2:0] MODE_SW_STROBE = 3'h4;
   localparam logic [2:0] MODE_HW_STROBE = 3'h5;
   // ==========================================================
   // reset values
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [1:0] SEQ_RST = SEQ_LSB;
   localparam logic [7:0] RDATA_RST = 8'h00;
   localparam logic OUT_RST = 1'b1;
   // ==========================================================
   // timing: counting clock up to 5 MHz against a 125 MHz clock
   localparam int CLK_MHZ = 125;
   localparam int CTR_CLK_MAX_MHZ = 5;
   localparam int CTR_CLK_MIN_CYC =
      (CLK_MHZ + CTR_CLK_MAX_MHZ - 1) / CTR_CLK_MAX_MHZ;
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} cnt_state_t;
endpackage

// ### verif/interval_timer_control_tb_top.sv
// self-checking testbench for the interval timer
`timescale 1ns/1ps
`default_nettype none

module interval_timer_control_tb_top;
   import interval_timer_pkg::*;
   // ==========================================================
   // stimulus and observation
   logic clock_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] wdata_i = 8'h00;
   logic [2:0] ctr_clk_i = 3'h0;
   logic [2:0] gate_i = 3'h7;
   logic [7:0] rdata_o;
   logic [2:0] timer_out_o;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   // 34 pulses of 61 cycles plus bus traffic, with ample margin
   localparam int CYCLE_LIMIT = 20000;
   // margin above the period of the fastest counter clock the synchronisers must resolve
   localparam int HALF = CTR_CLK_MIN_CYC + 5;

   interval_timer_control DUT (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .addr_i(addr_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .wdata_i(wdata_i),
      .rdata_o(rdata_o),
      .ctr_clk_i(ctr_clk_i),
      .gate_i(gate_i),
      .timer_out_o(timer_out_o)
   );

   initial begin
      forever #4 clock_i = ~clock_i;
   end

   // ==========================================================
   // verdict and hang guard
   task automatic give_verdict();
      if (miscompares == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == CYCLE_LIMIT) begin
         miscompares++;
         $display("unexpected at %0t: run did not finish", $time);
         give_verdict();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                        input string what);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s seen %h expected %h",
                  $time, what, seen, exp);
      end
   endtask

   // ==========================================================
   // host byte port and counter pins
   task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock_i);
      addr_i = a;
      wdata_i = d;
      wr_i = 1'b1;
      @(negedge clock_i);
      wr_i = 1'b0;
   endtask

   task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock_i);
      addr_i = a;
      rd_i = 1'b1;
      @(negedge clock_i);
      rd_i = 1'b0;
      @(negedge clock_i);
      d = rdata_o;
   endtask

   task automatic ctrl(input logic [1:0] k, input logic [1:0] seq,
                       input logic [2:0] mode, input logic bcd);
      bus_write(CTRL_WORD_OFS, {k, seq, mode, bcd});
   endtask

   task automatic load16(input int k, input logic [15:0] v);
      bus_write(CTR_DATA_OFS[k], v[7:0]);
      bus_write(CTR_DATA_OFS[k], v[15:8]);
   endtask

   task automatic pulse(input int k, input int n);
      repeat (n) begin
         @(negedge clock_i);
         ctr_clk_i[k] = 1'b1;
         repeat (HALF) @(negedge clock_i);
         ctr_clk_i[k] = 1'b0;
         repeat (HALF) @(negedge clock_i);
      end
   endtask

   // latch, then low byte and high byte
   task automatic read_count(input int k, output logic [15:0] v);
      logic [7:0] lo;
      logic [7:0] hi;
      ctrl(k[1:0], SEQ_LATCH, 3'h0, 1'b0);
      bus_read(CTR_DATA_OFS[k], lo);
      bus_read(CTR_DATA_OFS[k], hi);
      v = {hi, lo};
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset();
      logic [7:0] d;
      repeat (20) @(negedge clock_i);
      check(rdata_o, RDATA_RST, "read data in reset");
      check(timer_out_o, 3'h7, "outputs in reset");
      arst_n_i = 1'b1;
      repeat (5) @(negedge clock_i);
      bus_read(CTRL_WORD_OFS, d);
      check(d, 8'h00, "control port read");
      bus_read(8'h30, d);
      check(d, 8'h00, "unmapped read");
   endtask

   task automatic t_mode0();
      ctrl(2'h0, SEQ_BOTH, MODE_TC, 1'b0);
      @(negedge clock_i);
      check(timer_out_o[0], 1'b0, "mode 0 out after control");
      load16(0, 16'h0002);
      pulse(0, 2);
      check(timer_out_o[0], 1'b0, "mode 0 out before zero");
      gate_i[0] = 1'b0;
      pulse(0, 1);
      check(timer_out_o[0], 1'b0, "mode 0 paused by gate");
      gate_i[0] = 1'b1;
      pulse(0, 1);
      check(timer_out_o[0], 1'b1, "mode 0 terminal count");
      check(timer_out_o[2:1], 2'h3, "other counters untouched");
   endtask

   task automatic t_latch();
      logic [7:0] lo;
      logic [7:0] hi;
      logic [15:0] v;
      ctrl(2'h0, SEQ_BOTH, MODE_TC, 1'b0);
      load16(0, 16'h1234);
      pulse(0, 3);
      ctrl(2'h0, SEQ_LATCH, 3'h0, 1'b0);
      pulse(0, 2);
      bus_read(CTR_DATA_OFS[0], lo);
      bus_read(CTR_DATA_OFS[0], hi);
      check({hi, lo}, 16'h1232, "latched snapshot");
      read_count(0, v);
      check(v, 16'h1230, "counting went on under latch");
      ctrl(2'h0, SEQ_BOTH, MODE_TC, 1'b0);
      load16(0, 16'h0000);
      pulse(0, 2);
      read_count(0, v);
      check(v, 16'hffff, "binary count from zero");
   endtask

   task automatic t_bcd();
      logic [15:0] v;
      ctrl(2'h1, SEQ_BOTH, MODE_TC, 1'b1);
      load16(1, 16'h0010);
      pulse(1, 2);
      read_count(1, v);
      check(v, 16'h0009, "bcd decrement");
      ctrl(2'h1, SEQ_BOTH, MODE_TC, 1'b1);
      load16(1, 16'h0000);
      pulse(1, 2);
      read_count(1, v);
      check(v, 16'h9999, "bcd count from zero");
   endtask

   task automatic t_seq();
      logic [7:0] d;
      ctrl(2'h2, SEQ_LSB, MODE_TC, 1'b0);
      bus_write(CTR_DATA_OFS[2], 8'h34);
      pulse(2, 1);
      ctrl(2'h2, SEQ_LATCH, 3'h0, 1'b0);
      bus_read(CTR_DATA_OFS[2], d);
      check(d, 8'h34, "low byte only access");
      ctrl(2'h2, SEQ_MSB, MODE_TC, 1'b0);
      bus_write(CTR_DATA_OFS[2], 8'h12);
      pulse(2, 1);
      ctrl(2'h2, SEQ_LATCH, 3'h0, 1'b0);
      bus_read(CTR_DATA_OFS[2], d);
      check(d, 8'h12, "high byte only access");
      bus_read(CTRL_WORD_OFS, d);
      check(d, 8'h00, "control port read after data");
   endtask

   task automatic t_illegal();
      logic [15:0] v;
      ctrl(2'h0, SEQ_BOTH, MODE_TC, 1'b0);
      load16(0, 16'h0345);
      pulse(0, 1);
      bus_write(CTRL_WORD_OFS, 8'hd2);
      @(negedge clock_i);
      check(timer_out_o, 3'h0, "outputs after illegal select");
      read_count(0, v);
      check(v, 16'h0345, "counter 0 after illegal select");
   endtask

   task automatic t_modes();
      for (int m = 0; m < 8; m++) begin
         ctrl(2'h1, SEQ_BOTH, m[2:0], 1'b0);
         @(negedge clock_i);
         check(timer_out_o[1], (m != 0), "out after mode select");
      end
      // code 110 must act as the rate generator
      ctrl(2'h1, SEQ_BOTH, 3'h6, 1'b0);
      load16(1, 16'h0003);
      pulse(1, 2);
      check(timer_out_o[1], 1'b1, "rate out at count 2");
      pulse(1, 1);
      check(timer_out_o[1], 1'b0, "rate out at count 1");
      pulse(1, 1);
      check(timer_out_o[1], 1'b1, "rate out after reload");
   endtask

   // square wave, software strobe and gate-triggered one-shot
   task automatic t_waves();
      ctrl(2'h2, SEQ_BOTH, MODE_SQUARE, 1'b0);
      load16(2, 16'h0004);
      pulse(2, 3);
      check(timer_out_o[2], 1'b0, "square out first half");
      pulse(2, 2);
      check(timer_out_o[2], 1'b1, "square out second half");
      ctrl(2'h0, SEQ_BOTH, MODE_SW_STROBE, 1'b0);
      load16(0, 16'h0002);
      pulse(0, 3);
      check(timer_out_o[0], 1'b0, "strobe at zero");
      pulse(0, 1);
      check(timer_out_o[0], 1'b1, "strobe lasts one tick");
      ctrl(2'h1, SEQ_BOTH, MODE_ONESHOT, 1'b0);
      load16(1, 16'h0002);
      pulse(1, 1);
      check(timer_out_o[1], 1'b1, "one-shot waits for gate");
      gate_i[1] = 1'b0;
      repeat (5) @(negedge clock_i);
      gate_i[1] = 1'b1;
      repeat (5) @(negedge clock_i);
      check(timer_out_o[1], 1'b0, "one-shot triggered");
      pulse(1, 2);
      check(timer_out_o[1], 1'b1, "one-shot expired");
   endtask

   initial begin
      t_reset();
      t_mode0();
      t_latch();
      t_bcd();
      t_seq();
      t_illegal();
      t_modes();
      t_waves();
      give_verdict();
   end
endmodule

`default_nettype wire
